// >>> rtl/ddr_regs.svh
// Purpose: constants for the channel descriptor register block
// Assumes: one descriptor is a quad of 32-bit words
// Notes: field positions refer to the control/chain word
`ifndef DDR_REGS_SVH
`define DDR_REGS_SVH

`define DDR_WORD_BITS 32
`define DDR_DESC_BITS 128
`define DDR_HALF_BITS 16
`define DDR_NUM_SLOTS 18
`define DDR_CODE_BITS 5
`define DDR_SLOT_BITS 5

// control/chain word fields
`define DDR_TYPE_HI 31
`define DDR_TYPE_LO 29
`define DDR_TWO_DIM_BIT 27
`define DDR_LEN_HI 26
`define DDR_LEN_LO 25
`define DDR_CHAINING_ENABLE_BIT 22
`define DDR_TGT_HI 21
`define DDR_TGT_LO 17
`define DDR_BLK_HI 16
`define DDR_BLK_LO 15
`define DDR_PTR_HI 14
`define DDR_PTR_LO 0
`define DDR_PTR_BITS 15
`define DDR_ADDR_BITS 17

// endpoint type codes
`define DDR_TYPE_OFF 3'h0
`define DDR_TYPE_LINK 3'h1
`define DDR_TYPE_INT 3'h2
`define DDR_TYPE_RSV0 3'h3
`define DDR_TYPE_EXT 3'h4
`define DDR_TYPE_FLY 3'h5
`define DDR_TYPE_BOOT 3'h6
`define DDR_TYPE_RSV1 3'h7

// operand length codes
`define DDR_LEN_RSV 2'h0
`define DDR_LEN_NORM 2'h1
`define DDR_LEN_LONG 2'h2
`define DDR_LEN_QUAD 2'h3

`define DDR_BLK_RSV 2'h3

// chain target codes
`define DDR_TGT_MEM_LAST 5'h07
`define DDR_TGT_LTX_FIRST 5'h08
`define DDR_TGT_LTX_LAST 5'h0b
`define DDR_TGT_LRX_FIRST 5'h10
`define DDR_TGT_LRX_LAST 5'h13
`define DDR_TGT_RF0 5'h16
`define DDR_TGT_RF1 5'h17
`define DDR_SLOT_LRX_FIRST 5'h0c
`define DDR_SLOT_RF0 5'h10
`define DDR_SLOT_RF1 5'h11

`endif

// >>> rtl/ddr_pkg.sv
// Purpose: types for the channel descriptor register block
// Assumes: constants come from ddr_regs.svh
// Notes: word 0 (index) is the least significant word
`include "ddr_regs.svh"

package ddr_pkg;

  typedef struct packed {
    logic [`DDR_WORD_BITS-1:0] ctrl;
    logic [`DDR_WORD_BITS-1:0] y_word;
    logic [`DDR_WORD_BITS-1:0] x_word;
    logic [`DDR_WORD_BITS-1:0] index_word;
  } ddr_desc_s;

  typedef struct packed {
    logic active;
    logic done;
    logic error;
  } ddr_stat_s;

  typedef struct packed {
    logic [`DDR_WORD_BITS-1:0] index_word;
    logic [`DDR_HALF_BITS-1:0] x_count;
    logic [`DDR_HALF_BITS-1:0] x_modify;
    logic [`DDR_HALF_BITS-1:0] y_count;
    logic [`DDR_HALF_BITS-1:0] y_modify;
    logic [1:0] operand_length;
    logic two_dim_enable;
    logic [2:0] endpoint_type_field;
  } ddr_view_s;

  typedef enum logic [2:0] {
    DDR_ST_IDLE = 3'b001,
    DDR_ST_FETCH = 3'b010,
    DDR_ST_LOAD = 3'b100
  } ddr_state_e;

endpackage : ddr_pkg

// >>> rtl/ddr_desc_regs.sv
// Purpose: per-channel transfer descriptor registers with chain loading
// Assumes: all inputs come from logic on clk_in; descriptors arrive whole
// Notes: slot 16/17 are the register-fed receive channels
// Summary of operation
// - each descriptor is 128 bits: index, x, y and control/chain words
// - descriptors are written only as whole aligned quad-words
// - loading type 000 clears status (a same-cycle completion still sets done), flushes request counters, resets channel
// - loading a live descriptor into an active channel raises an interrupt
// - index word is a full 32-bit address
// - in 1D, x word holds modify low and count high
// - in 2D, x count is row length, x modify element step
// - in 2D, y word holds row count and row-to-row modify
// - y word is ignored when two-dimensional mode is off
// - control word: transfer control in upper bits, chaining in lower
// - chain pointer bits 14:0 give next descriptor address bits 16:2
// - block select bits 16:15 choose block 0..2; code 11 reserved
// - target bits 21:17; link transmit from 01000, link receive from 10000
// - memory channel n: source code 2n, destination code 2n+1
// - target 10111 selects register-fed receive channel in slot 17
// - chaining enable fetches next descriptor into the target channel
// - type bits 31:29 encode endpoint; 011 and 111 reserved
// - operand length 01/10/11; 00 reserved; index aligned to operand size
// - control bit 27 selects two-dimensional addressing
`timescale 1ns/1ps
`default_nettype none
`include "ddr_regs.svh"

module ddr_desc_regs #(
  parameter int NUM_SLOTS = `DDR_NUM_SLOTS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic [`DDR_CODE_BITS-1:0] wr_code_in,
  input wire ddr_pkg::ddr_desc_s wr_desc_in,
  input wire logic [`DDR_CODE_BITS-1:0] rd_code_in,
  output ddr_pkg::ddr_desc_s rd_desc_out,
  output ddr_pkg::ddr_stat_s rd_status_out,
  input wire logic [`DDR_CODE_BITS-1:0] view_code_in,
  output ddr_pkg::ddr_view_s view_out,
  input wire logic [NUM_SLOTS-1:0] done_in,
  output logic fetch_req_out,
  output logic [1:0] fetch_block_out,
  output logic [`DDR_ADDR_BITS-1:0] fetch_addr_out,
  input wire logic fetch_ack_in,
  input wire ddr_pkg::ddr_desc_s fetch_desc_in,
  output logic [NUM_SLOTS-1:0] active_out,
  output logic [NUM_SLOTS-1:0] flush_out,
  output logic irq_out,
  output logic chain_busy_out
);
  import ddr_pkg::*;

  // chain target code to storage slot; invalid codes have no slot
  function automatic logic [`DDR_SLOT_BITS:0] code_to_slot(input logic [`DDR_CODE_BITS-1:0] code);
    logic [`DDR_SLOT_BITS:0] r;
    r = '0;
    if (code <= `DDR_TGT_MEM_LAST) begin
      r = {1'b1, code};
    end else if (code >= `DDR_TGT_LTX_FIRST && code <= `DDR_TGT_LTX_LAST) begin
      r = {1'b1, code};
    end else if (code >= `DDR_TGT_LRX_FIRST && code <= `DDR_TGT_LRX_LAST) begin
      r = {1'b1, `DDR_SLOT_BITS'(code - `DDR_TGT_LRX_FIRST + `DDR_SLOT_LRX_FIRST)};
    end else if (code == `DDR_TGT_RF0) begin
      r = {1'b1, `DDR_SLOT_RF0};
    end else if (code == `DDR_TGT_RF1) begin
      r = {1'b1, `DDR_SLOT_RF1};
    end
    return r;
  endfunction : code_to_slot

  ddr_desc_s desc_reg [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] active_reg;
  logic [NUM_SLOTS-1:0] done_reg;
  logic [NUM_SLOTS-1:0] err_reg;
  logic [NUM_SLOTS-1:0] pend_reg;
  ddr_state_e st_reg;
  ddr_state_e st_next;
  ddr_desc_s hold_desc_reg;
  logic [`DDR_CODE_BITS-1:0] hold_code_reg;

  // load source: a host write takes the cycle, a held chain load waits
  wire chain_ld = (st_reg == DDR_ST_LOAD) && !wr_in;
  wire ld_en = wr_in || chain_ld;
  wire [`DDR_CODE_BITS-1:0] ld_code = wr_in ? wr_code_in : hold_code_reg;
  wire ddr_desc_s ld_desc = wr_in ? wr_desc_in : hold_desc_reg;
  wire [`DDR_SLOT_BITS:0] ld_map = code_to_slot(ld_code);
  wire ld_ok = ld_en && ld_map[`DDR_SLOT_BITS];
  wire [`DDR_SLOT_BITS-1:0] ld_slot = ld_map[`DDR_SLOT_BITS-1:0];

  // field decode of the word being loaded
  wire [2:0] ld_type = ld_desc.ctrl[`DDR_TYPE_HI:`DDR_TYPE_LO];
  wire [1:0] ld_len = ld_desc.ctrl[`DDR_LEN_HI:`DDR_LEN_LO];
  wire [1:0] ld_blk = ld_desc.ctrl[`DDR_BLK_HI:`DDR_BLK_LO];
  wire ld_chaining_enable = ld_desc.ctrl[`DDR_CHAINING_ENABLE_BIT];
  wire [`DDR_SLOT_BITS:0] ld_tgt_map = code_to_slot(ld_desc.ctrl[`DDR_TGT_HI:`DDR_TGT_LO]);
  wire ld_off = (ld_type == `DDR_TYPE_OFF);
  wire ld_type_bad = (ld_type == `DDR_TYPE_RSV0) || (ld_type == `DDR_TYPE_RSV1);
  wire ld_len_bad = (ld_len == `DDR_LEN_RSV);
  // alignment counted in 32-bit word addresses
  wire ld_misalign = ((ld_len == `DDR_LEN_LONG) && ld_desc.index_word[0]) ||
                     ((ld_len == `DDR_LEN_QUAD) && (ld_desc.index_word[1:0] != 2'h0));
  wire ld_chain_bad = ld_chaining_enable && ((ld_blk == `DDR_BLK_RSV) || !ld_tgt_map[`DDR_SLOT_BITS]);
  wire ld_bad = !ld_off && (ld_type_bad || ld_len_bad || ld_misalign || ld_chain_bad);
  wire ld_live = !ld_off && !ld_bad;
  wire ld_irq = ld_ok && ld_live && active_reg[ld_slot];

  // completion events from the data mover
  wire [NUM_SLOTS-1:0] done_ev = done_in & active_reg;

  // lowest pending chain request wins
  logic [`DDR_SLOT_BITS-1:0] sel_slot;
  always_comb begin
    sel_slot = '0;
    for (int k = NUM_SLOTS - 1; k >= 0; k--) begin
      if (pend_reg[k]) begin
        sel_slot = `DDR_SLOT_BITS'(k);
      end
    end
  end
  wire pick = (st_reg == DDR_ST_IDLE) && (pend_reg != '0);
  wire ddr_desc_s sel_desc = desc_reg[sel_slot];

  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      wire hit = ld_ok && (ld_slot == g);
      wire chaining_enable_now = desc_reg[g].ctrl[`DDR_CHAINING_ENABLE_BIT];
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          desc_reg[g] <= '0;
          active_reg[g] <= 1'b0;
          done_reg[g] <= 1'b0;
          err_reg[g] <= 1'b0;
          pend_reg[g] <= 1'b0;
          flush_out[g] <= 1'b0;
        end else begin
          if (hit) begin
            desc_reg[g] <= ld_desc;
          end
          // a new live load wins over completion of the old descriptor
          active_reg[g] <= hit ? ld_live : (active_reg[g] && !done_ev[g]);
          // completion is set-wins against the clear done by a load
          done_reg[g] <= done_ev[g] || (done_reg[g] && !hit);
          err_reg[g] <= hit ? ld_bad : err_reg[g];
          pend_reg[g] <= (done_ev[g] && chaining_enable_now) || (pend_reg[g] && !(hit && ld_off) &&
                         !(pick && sel_slot == g));
          flush_out[g] <= hit && ld_off;
        end
      end
    end
  endgenerate

  // chain fetch sequencer
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      DDR_ST_IDLE: begin
        if (pick) begin
          st_next = DDR_ST_FETCH;
        end
      end
      DDR_ST_FETCH: begin
        if (fetch_ack_in) begin
          st_next = DDR_ST_LOAD;
        end
      end
      DDR_ST_LOAD: begin
        if (!wr_in) begin
          st_next = DDR_ST_IDLE;
        end
      end
      default: st_next = DDR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= DDR_ST_IDLE;
      fetch_req_out <= 1'b0;
      fetch_block_out <= 2'h0;
      fetch_addr_out <= '0;
      hold_code_reg <= '0;
      hold_desc_reg <= '0;
    end else begin
      st_reg <= st_next;
      if (pick) begin
        fetch_req_out <= 1'b1;
        fetch_block_out <= sel_desc.ctrl[`DDR_BLK_HI:`DDR_BLK_LO];
        fetch_addr_out <= {sel_desc.ctrl[`DDR_PTR_HI:`DDR_PTR_LO], 2'h0};
        hold_code_reg <= sel_desc.ctrl[`DDR_TGT_HI:`DDR_TGT_LO];
      end else if (st_reg == DDR_ST_FETCH && fetch_ack_in) begin
        fetch_req_out <= 1'b0;
        hold_desc_reg <= fetch_desc_in;
      end
    end
  end

  // read and mover view ports
  wire [`DDR_SLOT_BITS:0] rd_map = code_to_slot(rd_code_in);
  wire [`DDR_SLOT_BITS:0] vw_map = code_to_slot(view_code_in);
  wire ddr_desc_s vw_desc = desc_reg[vw_map[`DDR_SLOT_BITS-1:0]];
  wire vw_2d = vw_desc.ctrl[`DDR_TWO_DIM_BIT];
  wire ddr_view_s vw_next = '{
    index_word: vw_desc.index_word,
    x_count: vw_desc.x_word[`DDR_WORD_BITS-1:`DDR_HALF_BITS],
    x_modify: vw_desc.x_word[`DDR_HALF_BITS-1:0],
    // a 1D transfer is one row with no row step
    y_count: vw_2d ? vw_desc.y_word[`DDR_WORD_BITS-1:`DDR_HALF_BITS] : `DDR_HALF_BITS'h1,
    y_modify: vw_2d ? vw_desc.y_word[`DDR_HALF_BITS-1:0] : `DDR_HALF_BITS'h0,
    operand_length: vw_desc.ctrl[`DDR_LEN_HI:`DDR_LEN_LO],
    two_dim_enable: vw_2d,
    endpoint_type_field: vw_desc.ctrl[`DDR_TYPE_HI:`DDR_TYPE_LO]
  };

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_desc_out <= '0;
      rd_status_out <= '0;
      view_out <= '0;
      active_out <= '0;
      irq_out <= 1'b0;
      chain_busy_out <= 1'b0;
    end else begin
      rd_desc_out <= rd_map[`DDR_SLOT_BITS] ? desc_reg[rd_map[`DDR_SLOT_BITS-1:0]] : '0;
      rd_status_out <= rd_map[`DDR_SLOT_BITS] ? ddr_stat_s'{active: active_reg[rd_map[`DDR_SLOT_BITS-1:0]],
                       done: done_reg[rd_map[`DDR_SLOT_BITS-1:0]],
                       error: err_reg[rd_map[`DDR_SLOT_BITS-1:0]]} : '0;
      view_out <= vw_map[`DDR_SLOT_BITS] ? vw_next : '0;
      active_out <= active_reg;
      irq_out <= ld_irq;
      chain_busy_out <= (st_next != DDR_ST_IDLE);
    end
  end

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  logic [`DDR_SLOT_BITS-1:0] ld_slot_q;
  logic ld_ok_q;
  ddr_desc_s ld_desc_q;
  always_ff @(posedge clk_in) begin
    ld_slot_q <= ld_slot;
    ld_ok_q <= ld_ok;
    ld_desc_q <= ld_desc;
  end

  a_irq_on_reload: assert property (
    ld_ok && ld_live && active_reg[ld_slot] |=> irq_out)
    else $error("no interrupt on live load into active channel");
  a_irq_cause: assert property (
    irq_out |-> $past(ld_ok) && $past(active_reg[ld_slot]))
    else $error("interrupt without live load into active channel");
  a_off_resets: assert property (
    ld_ok && ld_off |=> flush_out[ld_slot_q] && !active_reg[ld_slot_q] && !err_reg[ld_slot_q])
    else $error("off load did not reset channel");
  a_load_stores: assert property (
    ld_ok |=> desc_reg[ld_slot_q] == ld_desc_q)
    else $error("descriptor not stored on load");
  a_bad_block_err: assert property (
    ld_ok && !ld_off && ld_chaining_enable && ld_blk == `DDR_BLK_RSV |=> err_reg[ld_slot_q] && !active_reg[ld_slot_q])
    else $error("reserved block select accepted");
  a_misalign_err: assert property (
    ld_ok && !ld_off && ld_misalign |=> err_reg[ld_slot_q] ##1 !active_out[$past(ld_slot_q)])
    else $error("misaligned index accepted");
  a_fetch_held: assert property (
    fetch_req_out && !fetch_ack_in |=> fetch_req_out && $stable(fetch_addr_out) && $stable(fetch_block_out))
    else $error("fetch request dropped before ack");
  a_fetch_addr: assert property (
    pick |=> fetch_addr_out[1:0] == 2'h0 && fetch_addr_out[`DDR_ADDR_BITS-1:2] == $past(sel_desc.ctrl[14:0]))
    else $error("fetch address not built from chain pointer");
  a_chain_load: assert property (
    st_reg == DDR_ST_FETCH && fetch_ack_in |=> st_reg == DDR_ST_LOAD ##[0:8] chain_ld)
    else $error("fetched descriptor not loaded");
  a_view_1d_y: assert property (
    vw_map[`DDR_SLOT_BITS] && !vw_2d |=> view_out.y_count == 16'h1 &&
    view_out.y_modify == 16'h0)
    else $error("y word leaked in 1D mode");
  a_view_x_split: assert property (
    vw_map[`DDR_SLOT_BITS] |=> view_out.x_count == $past(vw_desc.x_word[31:16]) &&
    view_out.x_modify == $past(vw_desc.x_word[15:0]))
    else $error("x word halves swapped");

  // load outcome checks
  a_flush_single: assert property (
    flush_out != '0 |-> ld_ok_q && $onehot(flush_out))
    else $error("flush pulse without a single off load");
  a_flush_quiet: assert property (
    !(ld_ok && ld_off) |=> flush_out == '0)
    else $error("flush pulse without off load");
  a_type_rsv_err: assert property (
    ld_ok && !ld_off && ld_type_bad |=> err_reg[ld_slot_q] && !active_reg[ld_slot_q])
    else $error("reserved endpoint type accepted");
  a_len_rsv_err: assert property (
    ld_ok && !ld_off && ld_len_bad |=> err_reg[ld_slot_q] && !active_reg[ld_slot_q])
    else $error("reserved operand length accepted");
  a_target_rsv_err: assert property (
    ld_ok && !ld_off && ld_chaining_enable && !ld_tgt_map[`DDR_SLOT_BITS] |=> err_reg[ld_slot_q])
    else $error("invalid chain target accepted");
  a_live_activates: assert property (
    ld_ok && ld_live |=> active_reg[ld_slot_q] && !err_reg[ld_slot_q])
    else $error("live load did not activate channel");
  a_err_stable: assert property (
    !ld_ok |=> $stable(err_reg))
    else $error("error flag changed without a load");
  a_quiet_irq: assert property (
    ld_ok && !ld_live |=> !irq_out)
    else $error("interrupt on non-live load");

  // chain sequencer and view checks
  a_fetch_state: assert property (
    fetch_req_out |-> st_reg == DDR_ST_FETCH)
    else $error("fetch request outside fetch state");
  a_fetch_block: assert property (
    pick |=> fetch_block_out == $past(sel_desc.ctrl[16:15]))
    else $error("fetch block not taken from block select");
  a_busy_level: assert property (
    chain_busy_out == (st_reg != DDR_ST_IDLE))
    else $error("busy flag disagrees with sequencer");
  a_done_sets: assert property (
    done_ev != '0 |=> (done_reg & $past(done_ev)) == $past(done_ev))
    else $error("completion not recorded");
  a_read_invalid: assert property (
    !rd_map[`DDR_SLOT_BITS] |=> rd_desc_out == '0 && rd_status_out == '0)
    else $error("invalid read code returned data");
  a_view_index: assert property (
    vw_map[`DDR_SLOT_BITS] |=> view_out.index_word == $past(vw_desc.index_word))
    else $error("index word not passed to view");
  a_view_2d_y: assert property (
    vw_map[`DDR_SLOT_BITS] && vw_2d |=> view_out.y_count == $past(vw_desc.y_word[31:16]) &&
    view_out.y_modify == $past(vw_desc.y_word[15:0]))
    else $error("y word not passed in 2D mode");
  a_view_mode: assert property (
    vw_map[`DDR_SLOT_BITS] |=> view_out.two_dim_enable == $past(vw_desc.ctrl[27]) &&
    view_out.operand_length == $past(vw_desc.ctrl[26:25]))
    else $error("mode fields not passed to view");

  c_irq: cover property (irq_out);
  c_chain_cycle: cover property (pick ##[1:20] chain_ld);
  c_flush: cover property (flush_out != '0);
  c_view_2d: cover property (view_out.two_dim_enable);
  c_bad_load: cover property (ld_ok && ld_bad);

endmodule : ddr_desc_regs
`default_nettype wire

// >>> test/ddr_chain_mem.sv
// Purpose: chain memory answering descriptor fetches
// Assumes: one fetch outstanding at a time; bench fills mem
// Notes: delay_in sets answer latency, zero answers at once
`timescale 1ns/1ps
`default_nettype none
module ddr_chain_mem (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic [16:0] addr_in,
  input wire logic [7:0] delay_in,
  output logic ack_out,
  output ddr_pkg::ddr_desc_s desc_out
);
  import ddr_pkg::*;
  ddr_desc_s mem [0:7];
  logic [7:0] wait_reg;
  // data lines inverted each cycle outside the ack cycle, so a stale value reappears every other cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      wait_reg <= 8'h00;
      desc_out <= '0;
    end else if (req_in && !ack_out && wait_reg >= delay_in) begin
      ack_out <= 1'b1;
      desc_out <= mem[addr_in[4:2]];
    end else begin
      ack_out <= 1'b0;
      wait_reg <= (req_in && !ack_out) ? wait_reg + 8'h01 : 8'h00;
      desc_out <= ~desc_out;
    end
  end
endmodule : ddr_chain_mem
`default_nettype wire

// >>> test/dma_descriptor_registers_test.sv
// Purpose: self-checking bench for ddr_desc_regs
// Assumes: chain memory model answers fetch requests
// Notes: table rows cover load outcomes; events and chaining by hand
`timescale 1ns/1ps
`default_nettype none
module dma_descriptor_registers_test;
  import ddr_pkg::*;
  typedef struct packed {
    logic [4:0] code;
    logic [31:0] ctrl;
    logic [31:0] index;
    logic [2:0] stat;
    logic keep;
  } ddr_row_s;
  localparam logic [31:0] XW = 32'h0010_0004;
  localparam logic [31:0] YW = 32'h0003_0020;
  localparam ddr_desc_s CHAIN_D = {32'h4200_0000, YW, XW, 32'h0000_0040};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_in = 1'b0;
  logic [4:0] wr_code_in = 5'h00;
  ddr_desc_s wr_desc_in = '0;
  logic [4:0] rd_code_in = 5'h00;
  logic [4:0] view_code_in = 5'h00;
  logic [17:0] done_in = '0;
  logic [7:0] delay_in = 8'h00;
  ddr_desc_s rd_desc_out, fetch_desc_in, d;
  ddr_stat_s rd_status_out;
  ddr_view_s view_out, v;
  logic fetch_req_out, fetch_ack_in, irq_out, chain_busy_out;
  logic [1:0] fetch_block_out;
  logic [16:0] fetch_addr_out;
  logic [17:0] active_out, flush_out;
  int fails = 0;
  int total_checks = 0;
  ddr_row_s rows [13];
  always #50 clk_in = ~clk_in;
  ddr_desc_regs u_dut (.clk_in(clk_in), .rst_in(rst_in), .wr_in(wr_in), .wr_code_in(wr_code_in),
    .wr_desc_in(wr_desc_in), .rd_code_in(rd_code_in), .rd_desc_out(rd_desc_out),
    .rd_status_out(rd_status_out), .view_code_in(view_code_in), .view_out(view_out),
    .done_in(done_in), .fetch_req_out(fetch_req_out), .fetch_block_out(fetch_block_out),
    .fetch_addr_out(fetch_addr_out), .fetch_ack_in(fetch_ack_in), .fetch_desc_in(fetch_desc_in),
    .active_out(active_out), .flush_out(flush_out), .irq_out(irq_out), .chain_busy_out(chain_busy_out));
  ddr_chain_mem u_mem (.clk_in(clk_in), .rst_in(rst_in), .req_in(fetch_req_out), .addr_in(fetch_addr_out),
    .delay_in(delay_in), .ack_out(fetch_ack_in), .desc_out(fetch_desc_in));
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // leaves the strobe up; look drops it an edge later
  task automatic put(input logic [4:0] c, input logic [31:0] ctrl, input logic [31:0] idx);
    wr_in <= 1'b1;
    wr_code_in <= c;
    wr_desc_in <= {ctrl, YW, XW, idx};
    @(posedge clk_in);
  endtask : put
  task automatic look(input logic [4:0] c);
    wr_in <= 1'b0;
    rd_code_in <= c;
    view_code_in <= c;
    repeat (2) @(posedge clk_in);
  endtask : look
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3000) @(posedge clk_in);
    fails++;
    tally_and_finish();
  end
  initial begin
    u_mem.mem[3] = CHAIN_D;
    rows[0] = '{5'h00, 32'h4200_0000, 32'hfedc_ba98, 3'b100, 1'b1};
    rows[1] = '{5'h01, 32'h8e00_0000, 32'h0000_1004, 3'b100, 1'b1};
    rows[2] = '{5'h08, 32'h2400_0000, 32'h0000_2002, 3'b100, 1'b1};
    rows[3] = '{5'h10, 32'ha200_0000, 32'h0000_3001, 3'b100, 1'b1};
    rows[4] = '{5'h17, 32'hca00_0000, 32'h0000_4000, 3'b100, 1'b1};
    rows[5] = '{5'h07, 32'h6200_0000, 32'h0000_0010, 3'b001, 1'b1};
    rows[6] = '{5'h0b, 32'he200_0000, 32'h0000_0010, 3'b001, 1'b1};
    rows[7] = '{5'h13, 32'h4000_0000, 32'h0000_0010, 3'b001, 1'b1};
    rows[8] = '{5'h02, 32'h4600_0000, 32'h0000_1001, 3'b001, 1'b1};
    rows[9] = '{5'h03, 32'h4241_8000, 32'h0000_0010, 3'b001, 1'b1};
    rows[10] = '{5'h04, 32'h4258_0000, 32'h0000_0010, 3'b001, 1'b1};
    rows[11] = '{5'h0c, 32'h4200_0000, 32'h0000_0010, 3'b000, 1'b0};
    rows[12] = '{5'h16, 32'h4200_0000, 32'h0000_0020, 3'b100, 1'b1};
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    look(5'h00);
    chk("reset desc", '0, rd_desc_out);
    chk("reset status", '0, rd_status_out);
    foreach (rows[i]) begin
      put(rows[i].code, rows[i].ctrl, rows[i].index);
      look(rows[i].code);
      d = rows[i].keep ? {rows[i].ctrl, YW, XW, rows[i].index} : '0;
      v = '0;
      if (rows[i].keep) begin
        v = '{rows[i].index, XW[31:16], XW[15:0], rows[i].ctrl[27] ? YW[31:16] : 16'h0001,
          rows[i].ctrl[27] ? YW[15:0] : 16'h0000, rows[i].ctrl[26:25], rows[i].ctrl[27], rows[i].ctrl[31:29]};
      end
      chk("row desc", d, rd_desc_out);
      chk("row status", rows[i].stat, rd_status_out);
      chk("row view", v, view_out);
    end
    chk("active before", 1'b1, active_out[0]);
    put(5'h00, 32'h4200_0000, 32'hfedc_ba98);
    wr_in <= 1'b0;
    @(posedge clk_in);
    chk("irq pulse", 1'b1, irq_out);
    @(posedge clk_in);
    chk("irq drop", 1'b0, irq_out);
    put(5'h00, 32'h0000_0000, 32'h0000_0000);
    wr_in <= 1'b0;
    @(posedge clk_in);
    chk("flush", 18'h00001, flush_out);
    chk("no irq", 1'b0, irq_out);
    @(posedge clk_in);
    chk("active after", 1'b0, active_out[0]);
    look(5'h00);
    chk("cleared status", 3'b000, rd_status_out);
    // prompt answer first, then a slow one
    for (int k = 0; k < 2; k++) begin
      delay_in <= k ? 8'h06 : 8'h00;
      put(5'h05, 32'h424d_0003, 32'h0000_0100);
      look(5'h05);
      done_in[5] <= 1'b1;
      @(posedge clk_in);
      done_in <= '0;
      for (int i = 0; i < 40 && fetch_req_out !== 1'b1; i++) @(posedge clk_in);
      chk("fetch req", 1'b1, fetch_req_out);
      chk("fetch block", 2'b10, fetch_block_out);
      chk("fetch addr", 17'h0000c, fetch_addr_out);
      for (int i = 0; i < 40 && chain_busy_out !== 1'b0; i++) @(posedge clk_in);
      chk("chain idle", 1'b0, chain_busy_out);
      look(5'h06);
      chk("chained desc", CHAIN_D, rd_desc_out);
      chk("chained status", 3'b100, rd_status_out);
      look(5'h05);
      chk("done status", 3'b010, rd_status_out);
    end
    tally_and_finish();
  end
endmodule : dma_descriptor_registers_test
`default_nettype wire
